//--- dio_pkg.sv
// constants for the digital i/o command responder
package dio_pkg;
  localparam logic [15:0] GROUP_DIO = 16'h4000;
  // sub-command codes
  localparam logic [15:0] SUB_LAST_PAIR = 16'h0017;
  localparam logic [15:0] SUB_PORT_STATUS = 16'h0018;
  localparam logic [15:0] SUB_SET_MODE = 16'h0019;
  localparam logic [15:0] SUB_GET_MODE = 16'h001A;
  localparam logic [15:0] SUB_SET_EXTINT = 16'h056D;
  localparam logic [15:0] SUB_GET_EXTINT = 16'h06AD;
  // setting slots
  localparam int NUM_SETTINGS = 14;
  localparam logic [3:0] IDX_INVERT = 4'h7;
  localparam logic [3:0] IDX_PORTCFG = 4'h8;
  localparam logic [3:0] IDX_MODE = 4'hC;
  localparam logic [3:0] IDX_EXTINT = 4'hD;
  localparam logic [15:0] PORTCFG_MAX = 16'h000F;
  localparam logic [15:0] SETTING_RESET = 16'h0000;
  // class upper bytes
  localparam logic [7:0] CLS_SYNC_OK = 8'h88;
  localparam logic [7:0] CLS_ASYNC_OK = 8'h48;
  localparam logic [7:0] CLS_UNSOL_OK = 8'h28;
  localparam logic [7:0] CLS_SYNC_ERR = 8'h82;
  localparam logic [7:0] CLS_ASYNC_ERR = 8'h42;
  localparam logic [7:0] CLS_UNSOL_ERR = 8'h22;
  localparam logic [7:0] CLS_SYNC_CTL = 8'h81;
  localparam logic [7:0] CLS_ASYNC_CTL = 8'h41;
  localparam logic [7:0] CLS_UNSOL_CTL = 8'h21;
  // low bytes
  localparam logic [7:0] LO_ACK = 8'h00;
  localparam logic [7:0] LO_NACK = 8'h01;
  localparam logic [7:0] LO_COMPLETE = 8'h00;
  localparam logic [7:0] LO_PROGRESS = 8'h01;
  localparam logic [7:0] LO_LEN = 8'h00;
  localparam logic [7:0] LO_SEQ = 8'h01;
  localparam logic [7:0] LO_GROUP = 8'h03;
  localparam logic [7:0] LO_TIMEOUT = 8'h04;
  localparam logic [7:0] LO_FAILED = 8'h06;
  localparam logic [7:0] LO_SYSTEM = 8'h07;
  localparam logic [7:0] LO_SUBCMD = 8'h08;
  localparam logic [7:0] LO_ACKRSP = 8'h09;
  localparam logic [7:0] LO_CTLWORD = 8'h0A;
  localparam logic [7:0] LO_CMDDATA = 8'h0B;
  // expected command lengths in words
  localparam logic [15:0] LEN_SET = 16'h0002;
  localparam logic [15:0] LEN_GET = 16'h0001;
  // execution time limit
  localparam int EXEC_LIMIT_US = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXEC_LIMIT_CYC = EXEC_LIMIT_US * 1000 / CLK_PERIOD_NS;
  typedef enum {ST_IDLE, ST_SYNC_TX, ST_EXEC, ST_ASYNC_TX} dio_state_t;
  typedef enum {K_SET, K_GET, K_STATUS, K_BAD} dio_kind_t;
endpackage

//--- dio_cmd_responder.sv
// digital i/o command decoder and status response generator
// Behaviour
// - commands of group 4000H are decoded here; others are rejected
// - sub-commands 0000H..0017H decode as set (even) and get (odd) pairs
// - sub-command 0018H only reads the current port status
// - 056DH sets and 06ADH reads external interrupt control
// - ok responses use class byte 48 only; 88 and 28 are not sent
// - error responses use class bytes 82 and 42; 22 is not sent
// - control responses use class byte 81 only; 41 and 21 are not sent
// - valid data is acked with 8100H, invalid data nacked with 8101H
// - 4800H completes, 4801H shows progress, both echo the sub-command
// - length mismatch gives 8200H, expected then received length
// - sequence mismatch gives 8201H, expected then received number
// - unknown group gives 8203H with the group value
// - bad host acknowledge gives 8209H with that acknowledge value
// - async length mismatch gives 4200H, expected then received length
// - async sequence mismatch gives 4201H, expected then received number
// - async unknown group gives 4203H with the group value
// - execution over time limit gives 4204H without payload
// - failed execution gives 4206H with the sub-command
// - system fault gives 4207H without payload
// - unknown sub-command gives 4208H with the sub-command
// - bad control word gives 420AH, bad command data 420BH, no payload
`timescale 1ns/1ns
module dio_cmd_responder #(
  parameter int EXEC_TIMEOUT_CYC = dio_pkg::EXEC_LIMIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [15:0] cmdGroup,
  input wire logic [15:0] cmdSub,
  input wire logic [15:0] cmdLen,
  input wire logic [7:0] cmdSeq,
  input wire logic [15:0] cmdData,
  input wire logic cmdAsync,
  input wire logic cmdCtrlOk,
  input wire logic cmdDataOk,
  input wire logic ackValid,
  output logic ackReady,
  input wire logic [15:0] ackCode,
  output logic rspValid,
  input wire logic rspReady,
  output logic [15:0] rspWord,
  output logic rspLast,
  output logic applyReq,
  output logic [3:0] applyIdx,
  output logic [15:0] applyData,
  input wire logic applyDone,
  input wire logic applyFail,
  input wire logic sysFault,
  input wire logic [3:0] portPin,
  output logic [3:0] portDir
);
  import dio_pkg::*;

  dio_state_t state, next_state;
  logic [15:0] frm [0:2];
  logic [15:0] next_frm [0:2];
  logic [1:0] frmLen, next_frmLen, frmIdx, next_frmIdx;
  logic [15:0] aCode, next_aCode, aP0, next_aP0, aP1, next_aP1;
  logic [1:0] aLen, next_aLen;
  logic pendAsync, next_pendAsync, pendExec, next_pendExec;
  logic [15:0] curSub, next_curSub, curData, next_curData;
  logic [3:0] curIdx, next_curIdx;
  logic [7:0] expSeq, next_expSeq;
  logic [17:0] tmr, next_tmr;
  logic [15:0] setting [0:NUM_SETTINGS-1];
  logic [15:0] next_setting [0:NUM_SETTINGS-1];
  logic [3:0] pinS1, pinS2, pinS3, pinStable, next_pinStable;

  // decode of the incoming sub-command
  dio_kind_t kind;
  logic [3:0] kIdx;
  always_comb begin
    kind = K_BAD;
    kIdx = 4'h0;
    if (cmdSub <= SUB_LAST_PAIR) begin
      kind = cmdSub[0] ? K_GET : K_SET;
      kIdx = cmdSub[4:1];
    end else if (cmdSub == SUB_PORT_STATUS) begin
      kind = K_STATUS;
    end else if (cmdSub == SUB_SET_MODE) begin
      kind = K_SET;
      kIdx = IDX_MODE;
    end else if (cmdSub == SUB_GET_MODE) begin
      kind = K_GET;
      kIdx = IDX_MODE;
    end else if (cmdSub == SUB_SET_EXTINT) begin
      kind = K_SET;
      kIdx = IDX_EXTINT;
    end else if (cmdSub == SUB_GET_EXTINT) begin
      kind = K_GET;
      kIdx = IDX_EXTINT;
    end
  end

  // header checks, shared by sync and async reporting
  logic hdrErr;
  logic [7:0] errLo;
  logic [15:0] errP0, errP1, expLen;
  logic [1:0] errLen;
  always_comb begin
    hdrErr = 1'b1;
    errLo = LO_GROUP;
    errP0 = cmdGroup;
    errP1 = 16'h0000;
    errLen = 2'd2;
    expLen = (kind == K_SET) ? LEN_SET : LEN_GET;
    if (cmdGroup != GROUP_DIO) begin
      errLo = LO_GROUP;
    end else if (cmdSeq != expSeq) begin
      errLo = LO_SEQ;
      errP0 = {expSeq, cmdSeq};
    end else if (kind != K_BAD && cmdLen != expLen) begin
      errLo = LO_LEN;
      errP0 = expLen;
      errP1 = cmdLen;
      errLen = 2'd3;
    end else begin
      hdrErr = 1'b0;
    end
  end

  logic [3:0] portStatus;
  assign portStatus = pinStable ^ setting[IDX_INVERT][3:0];

  always_comb begin
    next_state = state;
    next_frm = frm;
    next_frmLen = frmLen;
    next_frmIdx = frmIdx;
    next_aCode = aCode;
    next_aP0 = aP0;
    next_aP1 = aP1;
    next_aLen = aLen;
    next_pendAsync = pendAsync;
    next_pendExec = pendExec;
    next_curSub = curSub;
    next_curData = curData;
    next_curIdx = curIdx;
    next_expSeq = expSeq;
    next_tmr = 18'd0;
    next_setting = setting;
    case (state)
      ST_IDLE: begin
        next_frmIdx = 2'd0;
        if (ackValid) begin
          if (ackCode != {CLS_SYNC_CTL, LO_ACK} &&
              ackCode != {CLS_SYNC_CTL, LO_NACK}) begin
            next_frm[0] = {CLS_SYNC_ERR, LO_ACKRSP};
            next_frm[1] = ackCode;
            next_frmLen = 2'd2;
            next_pendAsync = 1'b0;
            next_pendExec = 1'b0;
            next_state = ST_SYNC_TX;
          end
        end else if (cmdValid) begin
          next_expSeq = cmdSeq + 8'h01;
          next_curSub = cmdSub;
          next_curData = cmdData;
          next_curIdx = kIdx;
          next_pendExec = 1'b0;
          next_pendAsync = 1'b1;
          next_frm[0] = {CLS_SYNC_CTL, LO_ACK};
          next_frmLen = 2'd1;
          next_aLen = 2'd1;
          next_aP0 = cmdSub;
          next_aP1 = 16'h0000;
          next_state = ST_SYNC_TX;
          if (hdrErr && !cmdAsync) begin
            next_frm[0] = {CLS_SYNC_ERR, errLo};
            next_frm[1] = errP0;
            next_frm[2] = errP1;
            next_frmLen = errLen;
            next_pendAsync = 1'b0;
          end else if (hdrErr) begin
            next_aCode = {CLS_ASYNC_ERR, errLo};
            next_aP0 = errP0;
            next_aP1 = errP1;
            next_aLen = errLen;
          end else if (!cmdDataOk) begin
            next_frm[0] = {CLS_SYNC_CTL, LO_NACK};
            next_pendAsync = 1'b0;
          end else if (kind == K_BAD) begin
            next_aCode = {CLS_ASYNC_ERR, LO_SUBCMD};
            next_aLen = 2'd2;
          end else if (!cmdCtrlOk) begin
            next_aCode = {CLS_ASYNC_ERR, LO_CTLWORD};
          end else if (kind == K_SET && kIdx == IDX_PORTCFG &&
                       cmdData > PORTCFG_MAX) begin
            next_aCode = {CLS_ASYNC_ERR, LO_CMDDATA};
          end else if (kind == K_SET) begin
            next_aCode = {CLS_ASYNC_OK, LO_PROGRESS};
            next_aLen = 2'd2;
            next_pendExec = 1'b1;
          end else begin
            next_aCode = {CLS_ASYNC_OK, LO_COMPLETE};
            next_aP1 = (kind == K_STATUS) ? {12'h000, portStatus} :
                       setting[kIdx];
            next_aLen = 2'd3;
          end
        end
      end
      ST_SYNC_TX, ST_ASYNC_TX: begin
        if (rspReady) begin
          next_frmIdx = frmIdx + 2'd1;
          if (frmIdx == frmLen - 2'd1) begin
            next_frmIdx = 2'd0;
            next_state = ST_IDLE;
            if (pendAsync) begin
              // async status only after the sync one is out
              next_pendAsync = 1'b0;
              next_frm[0] = aCode;
              next_frm[1] = aP0;
              next_frm[2] = aP1;
              next_frmLen = aLen;
              next_state = ST_ASYNC_TX;
            end else if (pendExec) begin
              next_pendExec = 1'b0;
              next_state = ST_EXEC;
            end
          end
        end
      end
      ST_EXEC: begin
        next_tmr = tmr + 18'd1;
        next_frm[1] = curSub;
        next_frmLen = 2'd2;
        next_state = ST_ASYNC_TX;
        if (sysFault) begin
          next_frm[0] = {CLS_ASYNC_ERR, LO_SYSTEM};
          next_frmLen = 2'd1;
        end else if (applyFail) begin
          next_frm[0] = {CLS_ASYNC_ERR, LO_FAILED};
        end else if (applyDone) begin
          next_frm[0] = {CLS_ASYNC_OK, LO_COMPLETE};
          next_setting[curIdx] = curData;
        end else if (tmr == 18'(EXEC_TIMEOUT_CYC - 1)) begin
          next_frm[0] = {CLS_ASYNC_ERR, LO_TIMEOUT};
          next_frmLen = 2'd1;
        end else begin
          next_state = ST_EXEC;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      frmLen <= 2'd1;
      frmIdx <= 2'd0;
      aCode <= 16'h0000;
      aP0 <= 16'h0000;
      aP1 <= 16'h0000;
      aLen <= 2'd1;
      pendAsync <= 1'b0;
      pendExec <= 1'b0;
      curSub <= 16'h0000;
      curData <= 16'h0000;
      curIdx <= 4'h0;
      expSeq <= 8'h00;
      tmr <= 18'd0;
      for (int i = 0; i < 3; i++) begin
        frm[i] <= 16'h0000;
      end
      for (int i = 0; i < NUM_SETTINGS; i++) begin
        setting[i] <= SETTING_RESET;
      end
    end else begin
      state <= next_state;
      frm <= next_frm;
      frmLen <= next_frmLen;
      frmIdx <= next_frmIdx;
      aCode <= next_aCode;
      aP0 <= next_aP0;
      aP1 <= next_aP1;
      aLen <= next_aLen;
      pendAsync <= next_pendAsync;
      pendExec <= next_pendExec;
      curSub <= next_curSub;
      curData <= next_curData;
      curIdx <= next_curIdx;
      expSeq <= next_expSeq;
      tmr <= next_tmr;
      setting <= next_setting;
    end
  end

  // port pins: three-stage sync, change taken when stages two and three agree
  always_comb begin
    next_pinStable = pinStable;
    for (int i = 0; i < 4; i++) begin
      if (pinS2[i] == pinS3[i]) begin
        next_pinStable[i] = pinS3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinS1 <= 4'h0;
      pinS2 <= 4'h0;
      pinS3 <= 4'h0;
      pinStable <= 4'h0;
    end else begin
      pinS1 <= portPin;
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinStable <= next_pinStable;
    end
  end

  assign ackReady = (state == ST_IDLE);
  assign cmdReady = (state == ST_IDLE) && !ackValid;
  assign rspValid = (state == ST_SYNC_TX) || (state == ST_ASYNC_TX);
  assign rspWord = frm[frmIdx];
  assign rspLast = rspValid && (frmIdx == frmLen - 2'd1);
  assign applyReq = (state == ST_EXEC);
  assign applyIdx = curIdx;
  assign applyData = curData;
  assign portDir = setting[IDX_PORTCFG][3:0];
endmodule

//--- dio_cmd_chk.sv
// port assertions for the digital i/o command responder
`timescale 1ns/1ns
module dio_cmd_chk #(
  parameter int EXEC_TIMEOUT_CYC = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic ackValid,
  input wire logic ackReady,
  input wire logic [15:0] ackCode,
  input wire logic rspValid,
  input wire logic rspReady,
  input wire logic [15:0] rspWord,
  input wire logic rspLast,
  input wire logic applyReq,
  input wire logic [3:0] portDir
);
  logic codeWord, next_codeWord;
  int execCnt, next_execCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always_comb begin
    next_codeWord = (rspValid && rspReady) ? rspLast : codeWord;
    next_execCnt = applyReq ? execCnt + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      codeWord <= 1'b1;
      execCnt <= 0;
    end else begin
      codeWord <= next_codeWord;
      execCnt <= next_execCnt;
    end
  end
  a_code_legal: assert property (rspValid && codeWord |->
    rspWord inside
    {16'h8100, 16'h8101, 16'h8200, 16'h8201, 16'h8203, 16'h8209,
     16'h4800, 16'h4801, 16'h4200, 16'h4201, 16'h4203, 16'h4204,
     16'h4206, 16'h4207, 16'h4208, 16'h420A, 16'h420B})
    else $error("reserved response code");
  a_take_answer: assert property (cmdValid && cmdReady |=> rspValid &&
    rspWord[15:8] inside {8'h81, 8'h82}) else $error("no sync status");
  a_word_hold: assert property (rspValid && !rspReady |=> rspValid &&
    $stable(rspWord) && $stable(rspLast)) else $error("word not held");
  a_bad_ack: assert property (ackValid && ackReady &&
    !(ackCode inside {16'h8100, 16'h8101}) |=> rspValid &&
    rspWord == 16'h8209 && !rspLast) else $error("bad ack not flagged");
  a_good_ack: assert property (ackValid && ackReady &&
    ackCode inside {16'h8100, 16'h8101} |=> !rspValid [*2])
    else $error("good ack answered");
  a_ready_idle: assert property (cmdReady |-> !rspValid && !applyReq)
    else $error("ready while busy");
  a_exec_bound: assert property (applyReq |->
    execCnt < EXEC_TIMEOUT_CYC) else $error("execution overran");
  a_async_next: assert property (rspValid && rspReady && codeWord &&
    rspWord == 16'h8100 |=> rspValid && rspWord[15:12] == 4'h4)
    else $error("async status missing");
  a_dir_cause: assert property (!$stable(portDir) |-> $past(applyReq))
    else $error("port dir changed unbidden");
  cover property (ackValid && ackReady);
  cover property (applyReq ##1 !applyReq);
  cover property (rspValid && !rspReady);
endmodule
bind dio_cmd_responder dio_cmd_chk #(.EXEC_TIMEOUT_CYC(EXEC_TIMEOUT_CYC))
  u_chk (.core_clk, .rstn, .cmdValid, .cmdReady, .ackValid, .ackReady,
  .ackCode, .rspValid, .rspReady, .rspWord, .rspLast, .applyReq, .portDir);

//--- dio_host_model.sv
// response sink and setting executor on the host side
`timescale 1ns/1ns
module dio_host_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rspValid,
  output logic rspReady,
  input wire logic [15:0] rspWord,
  input wire logic applyReq,
  output logic applyDone,
  output logic applyFail,
  output logic sysFault,
  input wire logic [1:0] execMode,
  input wire logic slow
);
  logic [15:0] q[$];
  logic [3:0] cnt;
  // slow mode stalls every other cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rspReady <= 1'b0;
      cnt <= 4'h0;
      {applyDone, applyFail, sysFault} <= 3'b000;
    end else begin
      rspReady <= slow ? ~rspReady : 1'b1;
      if (rspValid && rspReady) q.push_back(rspWord);
      cnt <= applyReq ? cnt + 4'h1 : 4'h0;
      applyDone <= applyReq && execMode == 2'h0 && cnt == 4'h2;
      applyFail <= applyReq && execMode == 2'h1 && cnt == 4'h2;
      sysFault <= applyReq && execMode == 2'h2 && cnt == 4'h2;
    end
  end
endmodule

//--- tb.sv
// self-checking bench for the digital i/o command responder
`timescale 1ns/1ns
module tb;
  import dio_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic ackValid = 1'b0;
  logic cmdAsync = 1'b0;
  logic cmdCtrlOk = 1'b1;
  logic cmdDataOk = 1'b1;
  logic slow = 1'b0;
  logic [15:0] cmdGroup = 16'h0000, cmdSub = 16'h0000, cmdLen = 16'h0000;
  logic [15:0] cmdData = 16'h0000, ackCode = 16'h0000;
  logic [7:0] cmdSeq = 8'h00, seq = 8'h00;
  logic [3:0] portPin = 4'h0;
  logic [1:0] execMode = 2'h0;
  logic cmdReady, ackReady, rspValid, rspReady, rspLast, applyReq;
  logic applyDone, applyFail, sysFault;
  logic [15:0] rspWord, applyData;
  logic [3:0] applyIdx, portDir;
  logic [15:0] exp[$];
  int num_errors = 0;
  int n_compared = 0;
  always #2 core_clk = ~core_clk;
  dio_cmd_responder #(.EXEC_TIMEOUT_CYC(16)) u_dut (.core_clk, .rstn,
    .cmdValid, .cmdReady, .cmdGroup, .cmdSub, .cmdLen, .cmdSeq, .cmdData,
    .cmdAsync, .cmdCtrlOk, .cmdDataOk, .ackValid, .ackReady, .ackCode,
    .rspValid, .rspReady, .rspWord, .rspLast, .applyReq, .applyIdx,
    .applyData, .applyDone, .applyFail, .sysFault, .portPin, .portDir);
  dio_host_model u_host (.core_clk, .rstn, .rspValid, .rspReady, .rspWord,
    .applyReq, .applyDone, .applyFail, .sysFault, .execMode, .slow);
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // wait for idle, then compare every collected word
  task automatic settle();
    int n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!cmdReady && n < 400);
    check(16'(cmdReady), 16'h0001);
    check(16'(u_host.q.size()), 16'(exp.size()));
    foreach (exp[i]) check(u_host.q[i], exp[i]);
    exp.delete();
    u_host.q.delete();
  endtask
  task automatic send(input logic [15:0] g, s, l, d, input logic [2:0] f);
    int n = 0;
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdGroup <= g;
    cmdSub <= s;
    cmdLen <= l;
    cmdData <= d;
    cmdSeq <= seq;
    {cmdAsync, cmdCtrlOk, cmdDataOk} <= f;
    seq = seq + 8'h01;
    do begin
      @(posedge core_clk);
      n++;
    end while (!cmdReady && n < 400);
    check(16'(cmdReady), 16'h0001);
    cmdValid <= 1'b0;
    settle();
  endtask
  task automatic t_gets();
    for (int i = 1; i < 24; i += 2) begin
      exp = {16'h8100, 16'h4800, 16'(i), SETTING_RESET};
      send(GROUP_DIO, 16'(i), LEN_GET, 16'h0000, 3'b011);
    end
    exp = {16'h8100, 16'h4800, SUB_GET_EXTINT, SETTING_RESET};
    send(GROUP_DIO, SUB_GET_EXTINT, LEN_GET, 16'h0000, 3'b011);
  endtask
  task automatic t_sets();
    logic [15:0] g;
    logic [15:0] s[4] = '{16'h000E, 16'h0010, SUB_SET_MODE, SUB_SET_EXTINT};
    logic [3:0] k[4] = '{IDX_INVERT, IDX_PORTCFG, IDX_MODE, IDX_EXTINT};
    foreach (s[i]) begin
      g = (s[i] == SUB_SET_EXTINT) ? SUB_GET_EXTINT : s[i] + 16'h0001;
      exp = {16'h8100, 16'h4801, s[i], 16'h4800, s[i]};
      send(GROUP_DIO, s[i], LEN_SET, 16'(2 * i + 5), 3'b011);
      check(applyData, 16'(2 * i + 5));
      check({12'h000, applyIdx}, {12'h000, k[i]});
      exp = {16'h8100, 16'h4800, g, 16'(2 * i + 5)};
      send(GROUP_DIO, g, LEN_GET, 16'h0000, 3'b011);
    end
    check({12'h000, portDir}, 16'h0007);
  endtask
  task automatic t_status();
    portPin <= 4'hA;
    repeat (8) @(posedge core_clk);
    exp = {16'h8100, 16'h4800, SUB_PORT_STATUS, 16'h000F};
    send(GROUP_DIO, SUB_PORT_STATUS, LEN_GET, 16'h0000, 3'b011);
  endtask
  task automatic t_errs();
    logic [15:0] w;
    exp = {16'h8203, 16'h1234};
    send(16'h1234, 16'h0001, LEN_GET, 16'h0000, 3'b011);
    exp = {16'h8100, 16'h4203, 16'h1234};
    send(16'h1234, 16'h0001, LEN_GET, 16'h0000, 3'b111);
    w = {seq, seq + 8'h05};
    exp = {16'h8201, w};
    seq = seq + 8'h05;
    send(GROUP_DIO, 16'h0001, LEN_GET, 16'h0000, 3'b011);
    w = {seq, seq + 8'h05};
    exp = {16'h8100, 16'h4201, w};
    seq = seq + 8'h05;
    send(GROUP_DIO, 16'h0001, LEN_GET, 16'h0000, 3'b111);
    exp = {16'h8200, LEN_GET, 16'h0003};
    send(GROUP_DIO, 16'h0001, 16'h0003, 16'h0000, 3'b011);
    exp = {16'h8100, 16'h4200, LEN_GET, 16'h0003};
    send(GROUP_DIO, 16'h0001, 16'h0003, 16'h0000, 3'b111);
    exp = {16'h8100, 16'h4208, 16'h0020};
    send(GROUP_DIO, 16'h0020, LEN_GET, 16'h0000, 3'b011);
    exp = {16'h8100, 16'h420A};
    send(GROUP_DIO, 16'h0000, LEN_SET, 16'h0001, 3'b001);
    exp = {16'h8101};
    send(GROUP_DIO, 16'h0001, LEN_GET, 16'h0000, 3'b010);
    exp = {16'h8100, 16'h420B};
    send(GROUP_DIO, 16'h0010, LEN_SET, 16'h0010, 3'b011);
  endtask
  task automatic t_exec();
    logic [15:0] code[4] = '{16'h0000, 16'h4206, 16'h4207, 16'h4204};
    for (int m = 1; m < 4; m++) begin
      execMode <= 2'(m);
      exp = {16'h8100, 16'h4801, 16'h0002, code[m]};
      if (m == 1) exp.push_back(16'h0002);
      send(GROUP_DIO, 16'h2, LEN_SET, 16'h1, 3'b011);
    end
    execMode <= 2'h0;
  endtask
  task automatic t_ack(input logic [15:0] c, input logic bad);
    @(posedge core_clk);
    ackValid <= 1'b1;
    ackCode <= c;
    @(posedge core_clk);
    ackValid <= 1'b0;
    if (bad) exp = {16'h8209, c};
    settle();
  endtask
  // mid-run reset clears settings and the expected sequence number
  task automatic t_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({12'h000, portDir}, 16'h0000);
    check(applyData, 16'h0000);
    check({12'h000, applyIdx}, 16'h0000);
    check({14'h0000, rspValid, applyReq}, 16'h0000);
    rstn <= 1'b1;
    seq = 8'h00;
    exp = {16'h8100, 16'h4800, 16'h0011, SETTING_RESET};
    send(GROUP_DIO, 16'h0011, LEN_GET, 16'h0000, 3'b011);
  endtask
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    t_gets();
    t_sets();
    t_status();
    slow <= 1'b1;
    t_errs();
    slow <= 1'b0;
    t_exec();
    t_ack(16'h1234, 1'b1);
    t_ack(16'h8101, 1'b0);
    t_reset();
    print_verdict();
  end
endmodule
